// [rtl/ast_axis.sv]
// Per-axis status words and operation command handling
`timescale 1ns/1ps
module ast_axis
	import ast_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset,
	input  wire logic        i_clk_en,
	// Host command and status port
	input  wire logic        i_cmd_wr,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic        i_rd_n,
	output logic      [15:0] o_main_status,
	output logic      [15:0] o_sub_status,
	// Settings held elsewhere in the device
	input  wire logic        i_stop_irq_enable,
	input  wire logic        i_manual_clear_sel,
	input  wire logic [1:0]  i_step_number_field,
	input  wire logic [6:0]  i_op_mode_field,
	input  wire logic        i_sync_stop_enable,
	input  wire logic        i_sync_start_wait,
	input  wire logic        i_limit_counter_select,
	input  wire logic [31:0] i_counter_one,
	input  wire logic [31:0] i_counter_two,
	input  wire logic [31:0] i_compare_data_three,
	input  wire logic [31:0] i_compare_data_four,
	input  wire logic [10:0] i_error_factors,
	input  wire logic [19:0] i_event_factors,
	input  wire logic [31:0] i_remaining_count,
	input  wire logic        i_feed_amount_wr,
	input  wire logic        i_override_active,
	input  wire logic        i_preload_confirmed,
	// Pulse generator state
	input  wire logic        i_cmp_one_met,
	input  wire logic        i_cmp_two_met,
	input  wire logic        i_accelerating,
	input  wire logic        i_decelerating,
	input  wire logic        i_constant_speed,
	input  wire logic        i_motion_done,
	// Pins
	input  wire logic [7:0]  i_gp_pin_levels,
	input  wire logic        i_alarm_in,
	input  wire logic        i_pos_end_limit,
	input  wire logic        i_neg_end_limit,
	input  wire logic        i_origin_in,
	input  wire logic        i_slowdown_latched,
	input  wire logic        i_common_start_pin,
	output logic             o_common_start_pin_o,
	output logic             o_common_start_pin_oe,
	input  wire logic        i_common_stop_pin,
	output logic             o_common_stop_pin_o,
	output logic             o_common_stop_pin_oe,
	output logic             o_axis_active_n,
	// Requests to the pulse generator
	output logic             o_start_req,
	output logic      [1:0]  o_start_pattern,
	output logic             o_resume_req,
	output logic             o_speed_req,
	output logic      [1:0]  o_speed_sel,
	output logic             o_halt_now,
	output logic             o_ramp_halt,
	output logic             o_emg_all,
	output logic      [3:0]  o_run_condition
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [PIN_W-1:0] pin_s;
	logic             rd_s;
	logic             rd_d_r;
	logic             cstart_s;
	logic             cstart_d_r;
	logic             cstop_s;
	logic             cstop_d_r;

	ast_sync #(
		.W   (PIN_W),
		.RST (PIN_RST)
	) u_pin_sync (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_clk_en  (i_clk_en),
		.i_async   ({i_rd_n, i_common_start_pin, i_common_stop_pin,
		             i_slowdown_latched, i_origin_in, i_neg_end_limit,
		             i_pos_end_limit, i_alarm_in, i_gp_pin_levels}),
		.o_sync    (pin_s)
	);

	assign rd_s     = pin_s[15];
	assign cstart_s = pin_s[14];
	assign cstop_s  = pin_s[13];

	// Delayed copies for edge detection
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_d_r     <= 1'b1;
			cstart_d_r <= 1'b1;
			cstop_d_r  <= 1'b1;
		end else if (i_clk_en) begin
			rd_d_r     <= rd_s;
			cstart_d_r <= cstart_s;
			cstop_d_r  <= cstop_s;
		end
	end

	logic read_done;
	logic cstart_fall;
	logic cstop_fall;

	assign read_done   = rd_s & ~rd_d_r;
	assign cstart_fall = ~cstart_s & cstart_d_r;
	assign cstop_fall  = ~cstop_s & cstop_d_r;

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	logic cmd;
	logic is_start;
	logic is_resume;
	logic is_speed;
	logic is_grp_start;
	logic is_own_start;
	logic is_halt;
	logic is_ramp;
	logic is_emg;
	logic is_grp_stop;
	logic speed_mode;
	logic running;

	assign cmd          = i_cmd_wr & i_clk_en;
	assign is_start     = cmd && i_cmd_code >= CMD_START_LO && i_cmd_code <= CMD_START_HI;
	assign is_resume    = cmd && i_cmd_code >= CMD_RESUME_LO && i_cmd_code <= CMD_RESUME_HI &&
	                      i_op_mode_field == MODE_INCR;
	assign is_speed     = cmd && i_cmd_code >= CMD_SPEED_LO && i_cmd_code <= CMD_SPEED_HI;
	assign is_grp_start = cmd && i_cmd_code == CMD_GRP_START;
	assign is_own_start = cmd && i_cmd_code == CMD_OWN_START;
	assign is_halt      = cmd && i_cmd_code == CMD_HALT_NOW;
	assign is_ramp      = cmd && i_cmd_code == CMD_RAMP_HALT;
	assign is_emg       = cmd && i_cmd_code == CMD_EMG_ALL;
	assign is_grp_stop  = cmd && i_cmd_code == CMD_GRP_STOP;
	assign speed_mode   = i_op_mode_field == MODE_CONT_A ||
	                      i_op_mode_field == MODE_CONT_B ||
	                      i_op_mode_field == MODE_INCR;

	////////////////////////////////////////////////////////////////////////////
	// Axis activity state machine

	ast_state_t state_r;
	ast_state_t state_nxt;
	logic       pend_r;
	logic [1:0] pend_pat_r;
	logic       sync_stop;
	logic       stop_evt;
	logic       go;
	logic [1:0] go_pat;

	assign running   = state_r == ST_RUN || state_r == ST_STOP;
	assign sync_stop = i_sync_stop_enable & (is_grp_stop | cstop_fall);
	// Start signal for an axis waiting on the group start
	assign go        = is_grp_start | is_own_start | cstart_fall;

	// Next state from commands and motion completion
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (is_start || is_resume) begin
					state_nxt = i_sync_start_wait ? ST_WAIT : ST_RUN;
				end
			end
			ST_WAIT: begin
				if (is_halt || is_emg || is_ramp || sync_stop) begin
					state_nxt = ST_IDLE;
				end else if (go) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (is_halt || is_emg || sync_stop) begin
					state_nxt = ST_IDLE;
				end else if (is_ramp) begin
					state_nxt = ST_STOP;
				end else if (i_motion_done) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_STOP: begin
				if (is_halt || is_emg || sync_stop || i_motion_done) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// A queued start launches the next operation when this one ends, unless it ends on 49h or 05h
	assign stop_evt = running && state_nxt == ST_IDLE && i_clk_en;
	assign go_pat   = pend_r ? pend_pat_r : i_cmd_code[1:0];

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r <= ST_IDLE;
		end else if (i_clk_en) begin
			if (stop_evt && pend_r && !is_emg && !is_halt) begin
				state_r <= i_sync_start_wait ? ST_WAIT : ST_RUN;
			end else begin
				state_r <= state_nxt;
			end
		end
	end

	// Start held while running becomes the next start
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			pend_r     <= 1'b0;
			pend_pat_r <= 2'b00;
		end else if (i_clk_en) begin
			if (is_start && running) begin
				pend_r     <= 1'b1;
				pend_pat_r <= i_cmd_code[1:0];
			end else if (stop_evt || is_emg) begin
				pend_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Requests to the pulse generator

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_start_req     <= 1'b0;
			o_start_pattern <= 2'b00;
			o_resume_req    <= 1'b0;
			o_speed_req     <= 1'b0;
			o_speed_sel     <= 2'b00;
			o_halt_now      <= 1'b0;
			o_ramp_halt     <= 1'b0;
			o_emg_all       <= 1'b0;
		end else if (i_clk_en) begin
			o_start_req  <= (is_start && state_r == ST_IDLE) ||
			                (stop_evt && pend_r && !is_emg && !is_halt);
			o_resume_req <= is_resume && state_r == ST_IDLE &&
			                i_op_mode_field == MODE_INCR;
			o_speed_req  <= is_speed && running && speed_mode;
			o_halt_now   <= (is_halt || sync_stop) && state_r != ST_IDLE;
			o_ramp_halt  <= is_ramp && state_r == ST_RUN;
			o_emg_all    <= is_emg;
			if (is_start || is_resume) begin
				o_start_pattern <= i_cmd_code[1:0];
			end else if (stop_evt && pend_r) begin
				o_start_pattern <= go_pat;
			end
			if (is_speed) begin
				o_speed_sel <= i_cmd_code[1:0];
			end
		end
	end

	// Busy pin and run condition
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_axis_active_n <= 1'b1;
			o_run_condition <= COND_IDLE;
		end else if (i_clk_en) begin
			o_axis_active_n <= ~(state_r == ST_RUN || state_r == ST_STOP);
			case (state_r)
				ST_WAIT: o_run_condition <= COND_SYNC;
				ST_RUN:  o_run_condition <= COND_RUN;
				ST_STOP: o_run_condition <= COND_RUN;
				default: o_run_condition <= COND_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Common pin one-shots

	ast_pulse u_start_pulse (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_clk_en  (i_clk_en),
		.i_fire    (is_grp_start),
		.o_pin_o   (o_common_start_pin_o),
		.o_pin_oe  (o_common_start_pin_oe)
	);

	ast_pulse u_stop_pulse (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_clk_en  (i_clk_en),
		.i_fire    (is_grp_stop),
		.o_pin_o   (o_common_stop_pin_o),
		.o_pin_oe  (o_common_stop_pin_oe)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sticky status flags

	logic start_wr_r;
	logic stopped_r;
	logic stop_irq_r;
	logic off_tgt_r;
	logic clr_stop;
	logic clr_offt;
	logic starting;

	assign starting = is_start || is_resume;
	assign clr_stop = i_manual_clear_sel ? (cmd && i_cmd_code == CMD_CLR_STOP)
	                                     : read_done;
	assign clr_offt = i_manual_clear_sel ? (cmd && i_cmd_code == CMD_CLR_OFFT)
	                                     : read_done;

	// Start written and stopped flags
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			start_wr_r <= 1'b0;
			stopped_r  <= 1'b0;
		end else if (i_clk_en) begin
			if (starting) begin
				start_wr_r <= 1'b1;
				stopped_r  <= 1'b0;
			end else if (stop_evt) begin
				start_wr_r <= pend_r && !is_emg && !is_halt;
				stopped_r  <= 1'b1;
			end
		end
	end

	// Stop interrupt, set wins over clear
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			stop_irq_r <= 1'b0;
		end else if (i_clk_en) begin
			if (!i_stop_irq_enable) begin
				stop_irq_r <= 1'b0;
			end else if (stop_evt) begin
				stop_irq_r <= 1'b1;
			end else if (clr_stop) begin
				stop_irq_r <= 1'b0;
			end
		end
	end

	// Stopped short of the target, set wins over clear
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			off_tgt_r <= 1'b0;
		end else if (i_clk_en) begin
			if ((i_feed_amount_wr && state_r == ST_IDLE && !i_override_active) ||
			    (stop_evt && i_remaining_count != 32'h00000000)) begin
				off_tgt_r <= 1'b1;
			end else if (clr_offt || starting) begin
				off_tgt_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status word assembly and refresh

	logic [31:0] lim_cnt;
	logic [15:0] main_nxt;
	logic [15:0] sub_nxt;

	assign lim_cnt = i_limit_counter_select ? i_counter_two : i_counter_one;

	// Main status word
	always_comb begin
		main_nxt                        = STATUS_RST;
		main_nxt[MS_START_WR]           = start_wr_r;
		main_nxt[MS_RUNNING]            = running;
		main_nxt[MS_STOP_IRQ]           = stop_irq_r;
		main_nxt[MS_STOPPED]            = stopped_r;
		main_nxt[MS_ERR_IRQ]            = |i_error_factors;
		main_nxt[MS_EVT_IRQ]            = |i_event_factors;
		main_nxt[MS_STEP_HI:MS_STEP_LO] = i_step_number_field;
		main_nxt[MS_CMP_ONE]            = i_cmp_one_met;
		main_nxt[MS_CMP_TWO]            = i_cmp_two_met;
		main_nxt[MS_POS_LIM]            = $signed(lim_cnt) > $signed(i_compare_data_three);
		main_nxt[MS_NEG_LIM]            = $signed(lim_cnt) < $signed(i_compare_data_four);
		main_nxt[MS_RSVD_LO]            = 1'b0;
		main_nxt[MS_OFF_TGT]            = off_tgt_r;
		main_nxt[MS_PRELOAD]            = i_preload_confirmed;
		main_nxt[MS_RSVD_HI]            = 1'b0;
	end

	// Sub status word from synchronised pins and speed phase
	always_comb begin
		sub_nxt                       = STATUS_RST;
		sub_nxt[SS_GP_LO +: 8]        = pin_s[7:0];
		sub_nxt[SS_ACCEL]             = i_accelerating;
		sub_nxt[SS_DECEL]             = i_decelerating;
		sub_nxt[SS_CONST]             = i_constant_speed;
		sub_nxt[SS_ALARM +: 5]        = pin_s[12:8];
	end

	// Words hold still while the read strobe is low
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_main_status <= STATUS_RST;
			o_sub_status  <= STATUS_RST;
		end else if (i_clk_en && rd_s) begin
			o_main_status <= main_nxt;
			o_sub_status  <= sub_nxt;
		end
	end

endmodule // ast_axis

// [rtl/ast_pulse.sv]
// Open-drain one-shot driver for a common start or stop pin
`timescale 1ns/1ps
module ast_pulse
	import ast_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_reset,
	input  wire logic i_clk_en,
	input  wire logic i_fire,
	output logic      o_pin_o,
	output logic      o_pin_oe
);

	logic [3:0] cnt_r;

	// Pull low for a fixed count; a new fire restarts the count
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r    <= 4'h0;
			o_pin_oe <= 1'b0;
			o_pin_o  <= 1'b0;
		end else if (i_clk_en) begin
			o_pin_o <= 1'b0;
			if (i_fire) begin
				cnt_r    <= PULSE_CNT - 4'h1;
				o_pin_oe <= 1'b1;
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end else begin
				o_pin_oe <= 1'b0;
			end
		end
	end

endmodule // ast_pulse

// [rtl/ast_sync.sv]
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module ast_sync
	import ast_pkg::*;
#(
	parameter int             W   = 1,
	parameter logic [W-1:0]   RST = '0
)(
	input  wire logic         i_sys_clk,
	input  wire logic         i_reset,
	input  wire logic         i_clk_en,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_r <= RST;
			o_sync <= RST;
		end else if (i_clk_en) begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule // ast_sync

// [shared/ast_pkg.sv]
// Constants and types shared by the axis status and command logic
// Operation
// - Bit 0: start written, cleared at stop unless a queued start launches
// - Bit 1: running, mirrors inverted busy pin
// - Bit 2: stop interrupt, zero when disabled
// - Stop interrupt clears after read or 2Dh
// - Bit 3: stopped, cleared by start
// - Bits 4,5: error/event, clear when factors zero
// - Bits 7,6: sequence number from mode setting
// - Bits 8,9: comparator one and two met
// - Bit 10: selected counter above compare three
// - Bit 11: selected counter below compare four
// - Bit 13: feed written idle or remaining count
// - Off-target flag clears after read or 2Eh
// - Bit 14: continuous pre-register confirmed
// - Sub bits 7..0: general-purpose pin levels
// - Sub bits 8..10: accel, decel, constant
// - Sub bits 11..15: alarm, limits, origin, slowdown
// - 50h..53h start, or queue while running
// - 54h..57h resume in mode 41h, idle only
// - 06h pulses start pin; 2Ah starts own
// - 40h..43h speed change in modes 00h, 08h, 41h, ignored when stopped
// - 49h, 4Ah, 05h stop and leave mode
// - 07h pulses stop pin, stops if enabled
// - Status refreshes only while read strobe high
package ast_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Main status bit positions
	localparam int MS_START_WR  = 0;
	localparam int MS_RUNNING   = 1;
	localparam int MS_STOP_IRQ  = 2;
	localparam int MS_STOPPED   = 3;
	localparam int MS_ERR_IRQ   = 4;
	localparam int MS_EVT_IRQ   = 5;
	localparam int MS_STEP_LO   = 6;
	localparam int MS_STEP_HI   = 7;
	localparam int MS_CMP_ONE   = 8;
	localparam int MS_CMP_TWO   = 9;
	localparam int MS_POS_LIM   = 10;
	localparam int MS_NEG_LIM   = 11;
	localparam int MS_RSVD_LO   = 12;
	localparam int MS_OFF_TGT   = 13;
	localparam int MS_PRELOAD   = 14;
	localparam int MS_RSVD_HI   = 15;

	////////////////////////////////////////////////////////////////////////////
	// Sub status bit positions
	localparam int SS_GP_LO     = 0;
	localparam int SS_ACCEL     = 8;
	localparam int SS_DECEL     = 9;
	localparam int SS_CONST     = 10;
	localparam int SS_ALARM     = 11;

	// Reset value of both status words
	localparam logic [15:0] STATUS_RST = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [7:0] CMD_EMG_ALL   = 8'h05;
	localparam logic [7:0] CMD_GRP_START = 8'h06;
	localparam logic [7:0] CMD_GRP_STOP  = 8'h07;
	localparam logic [7:0] CMD_OWN_START = 8'h2A;
	localparam logic [7:0] CMD_CLR_STOP  = 8'h2D;
	localparam logic [7:0] CMD_CLR_OFFT  = 8'h2E;
	localparam logic [7:0] CMD_SPEED_LO  = 8'h40;
	localparam logic [7:0] CMD_SPEED_HI  = 8'h43;
	localparam logic [7:0] CMD_HALT_NOW  = 8'h49;
	localparam logic [7:0] CMD_RAMP_HALT = 8'h4A;
	localparam logic [7:0] CMD_START_LO  = 8'h50;
	localparam logic [7:0] CMD_START_HI  = 8'h53;
	localparam logic [7:0] CMD_RESUME_LO = 8'h54;
	localparam logic [7:0] CMD_RESUME_HI = 8'h57;

	////////////////////////////////////////////////////////////////////////////
	// Operation modes and run conditions
	localparam logic [6:0] MODE_CONT_A   = 7'h00;
	localparam logic [6:0] MODE_CONT_B   = 7'h08;
	localparam logic [6:0] MODE_INCR     = 7'h41;
	localparam logic [3:0] COND_IDLE     = 4'h0;
	localparam logic [3:0] COND_SYNC     = 4'h2;
	localparam logic [3:0] COND_RUN      = 4'hF;

	// One-shot low time on the common pins, in ns, and its cycle count
	localparam int CLK_PERIOD_NS = 8;
	localparam int PULSE_NS      = 80;
	localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYC);

	// Synchronised pin vector layout
	localparam int PIN_W = 16;
	localparam logic [PIN_W-1:0] PIN_RST = 16'hE000;

	// Axis activity states, Gray along idle-wait-run-stopping
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN  = 2'b11,
		ST_STOP = 2'b10
	} ast_state_t;

endpackage

// [sim/ast_axis_bench.sv]
// Self-checking bench for the axis status and command block
`timescale 1ns/1ps
`define CK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module ast_axis_bench
	import ast_pkg::*;
;
	logic i_sys_clk = 0, i_reset = 1, i_clk_en = 1;
	logic i_stop_irq_enable = 0, i_manual_clear_sel = 0, i_sync_stop_enable = 0;
	logic i_sync_start_wait = 0, i_limit_counter_select = 0, i_feed_amount_wr = 0;
	logic i_override_active = 0, i_preload_confirmed = 0, i_cmp_one_met = 0, i_cmp_two_met = 0;
	logic i_accelerating = 0, i_decelerating = 0, i_constant_speed = 0, i_motion_done = 0;
	logic i_alarm_in = 0, i_pos_end_limit = 0, i_neg_end_limit = 0, i_origin_in = 0;
	logic i_slowdown_latched = 0;
	logic [1:0]	i_step_number_field = 0;
	logic [6:0]	i_op_mode_field = 0;
	logic [7:0]	i_gp_pin_levels = 0;
	logic [10:0]	i_error_factors = 0;
	logic [19:0]	i_event_factors = 0;
	logic [31:0]	i_counter_one = 0, i_counter_two = 0, i_compare_data_three = 0;
	logic [31:0]	i_compare_data_four = 0, i_remaining_count = 0;
	wire		i_cmd_wr, i_rd_n;
	wire [7:0]	i_cmd_code;
	logic [15:0]	o_main_status, o_sub_status;
	logic [1:0]	o_start_pattern, o_speed_sel;
	logic [3:0]	o_run_condition;
	logic o_common_start_pin_o, o_common_start_pin_oe, o_common_stop_pin_o, o_common_stop_pin_oe;
	logic o_axis_active_n, o_start_req, o_resume_req, o_speed_req, o_halt_now, o_ramp_halt;
	logic o_emg_all;
	// Open-drain common pins with pull-ups
	wire i_common_start_pin = ~o_common_start_pin_oe;
	wire i_common_stop_pin = ~o_common_stop_pin_oe;
	int error_cnt = 0, cmp_count = 0;
	int cnt [8] = '{default: 0};
	wire [7:0] pv = {o_common_stop_pin_oe, o_common_start_pin_oe, o_emg_all, o_ramp_halt,
		o_halt_now, o_speed_req, o_resume_req, o_start_req};

	ast_axis dut_u (.*);
	ast_host host_u (.i_sys_clk(i_sys_clk), .o_cmd_wr(i_cmd_wr), .o_cmd_code(i_cmd_code),
		.o_rd_n(i_rd_n));

	////////////////////////////////////////////////////////////////////////////
	// Clock and high cycles of every request output
	always #4 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		for (int k = 0; k < 8; k++) cnt[k] += pv[k];
	end

	task step(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task go(input logic [7:0] c);
		host_u.cmd(c);
	endtask
	task done_pulse;
		i_motion_done = 1;
		step(1);
		i_motion_done = 0;
	endtask
	task feed_pulse;
		i_feed_amount_wr = 1;
		step(1);
		i_feed_amount_wr = 0;
	endtask
	task give_verdict;
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_run;
		i_stop_irq_enable = 1;
		i_remaining_count = 32'h5;
		go(8'h50); step(6);
		`CK(cnt[0], 1)
		`CK(o_main_status[3:0], 4'h3)
		`CK(o_axis_active_n, 1'h0)
		go(8'h53); go(8'h41); step(6);
		`CK(cnt[2], 1)
		`CK(o_speed_sel, 2'h1)
		go(8'h49); step(6);
		`CK(cnt[3], 1)
		`CK(o_main_status[3:0], 4'hC)
		`CK(o_main_status[13], 1'h1)
		`CK(cnt[0], 1)
		i_remaining_count = 0;
		host_u.rd_word(); step(6);
		`CK({o_main_status[13], o_main_status[2]}, 2'h0)
		i_stop_irq_enable = 0;
		go(8'h52); go(8'h4A); step(3); done_pulse(); step(6);
		`CK(cnt[4], 1)
		`CK(o_main_status[3:1], 3'h4)
	endtask

	task t_manual;
		i_manual_clear_sel = 1;
		i_stop_irq_enable = 1;
		go(8'h50); go(8'h05); step(6);
		`CK(cnt[5], 1)
		`CK(o_main_status[3:2], 2'h3)
		host_u.rd_word(); step(6);
		`CK(o_main_status[2], 1'h1)
		go(8'h2D); step(6);
		`CK(o_main_status[2], 1'h0)
		i_override_active = 1;
		feed_pulse(); step(6);
		`CK(o_main_status[13], 1'h0)
		i_override_active = 0;
		feed_pulse(); step(6);
		`CK(o_main_status[13], 1'h1)
		go(8'h2E); step(6);
		`CK(o_main_status[13], 1'h0)
		i_manual_clear_sel = 0;
	endtask

	task t_status;
		i_step_number_field = 2'h2; i_gp_pin_levels = 8'hA5; i_error_factors = 11'h1;
		i_counter_one = 32'hA; i_compare_data_three = 32'h5; i_compare_data_four = 32'h14;
		i_cmp_one_met = 1; i_preload_confirmed = 1; i_accelerating = 1;
		i_alarm_in = 1; i_origin_in = 1;
		step(8);
		`CK(o_main_status & 16'h4FF0, 16'h4D90)
		`CK(o_sub_status, 16'h49A5)
		i_limit_counter_select = 1; i_counter_two = 32'hFFFFFFFF; i_error_factors = 11'h0;
		i_event_factors = 20'h3; i_accelerating = 0; i_decelerating = 1; i_alarm_in = 0;
		i_origin_in = 0; i_pos_end_limit = 1; i_slowdown_latched = 1; i_gp_pin_levels = 8'h5A;
		step(8);
		`CK(o_main_status & 16'h0C30, 16'h0820)
		`CK(o_sub_status, 16'h925A)
	endtask

	task t_group;
		go(8'h06); step(14);
		`CK(cnt[6], 10)
		go(8'h07); step(14);
		`CK(cnt[7], 10)
		i_sync_start_wait = 1;
		go(8'h50); step(6);
		`CK(o_run_condition, COND_SYNC)
		go(8'h2A); step(6);
		`CK(o_run_condition, COND_RUN)
		`CK(cnt[6], 10)
		i_sync_stop_enable = 1;
		go(8'h07); step(12); done_pulse(); step(6);
		`CK({o_main_status[3], o_main_status[1]}, 2'h2)
		go(8'h50); go(8'h06); step(6);
		`CK(o_run_condition, COND_RUN)
		go(8'h49); step(6);
		i_sync_start_wait = 0;
		i_sync_stop_enable = 0;
	endtask

	task t_resume;
		go(8'h54); step(6);
		`CK(o_axis_active_n, 1'h1)
		i_op_mode_field = MODE_INCR;
		go(8'h40); step(6);
		`CK(cnt[2], 1)
		go(8'h55); step(6);
		`CK(cnt[1], 1)
		`CK(o_start_pattern, 2'h1)
		go(8'h49); step(6);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence and hang guard
	initial begin
		repeat (3) @(posedge i_sys_clk);
		#1;
		i_reset = 0;
		step(6);
		`CK(o_main_status, STATUS_RST)
		`CK(o_sub_status, STATUS_RST)
		t_run();
		t_manual();
		t_status();
		t_group();
		t_resume();
		give_verdict();
	end
	initial begin
		#400000;
		error_cnt++;
		give_verdict();
	end
endmodule // ast_axis_bench

// [sim/ast_axis_monitor.sv]
// Assertion checker for the axis status and command block
`timescale 1ns/1ps
module ast_axis_monitor
	import ast_pkg::*;
(
	input	wire logic		i_sys_clk,
	input	wire logic		i_reset,
	input	wire logic		i_clk_en,
	input	wire logic		i_cmd_wr,
	input	wire logic [7:0]	i_cmd_code,
	input	wire logic		i_rd_n,
	input	wire logic		i_stop_irq_enable,
	input	wire logic		i_sync_start_wait,
	input	wire logic [1:0]	i_step_number_field,
	input	wire logic [10:0]	i_error_factors,
	input	wire logic [7:0]	i_gp_pin_levels,
	input	wire logic [15:0]	o_main_status,
	input	wire logic [15:0]	o_sub_status,
	input	wire logic		o_start_req,
	input	wire logic [1:0]	o_start_pattern,
	input	wire logic		o_emg_all,
	input	wire logic [3:0]	o_run_condition,
	input	wire logic		o_common_start_pin_o,
	input	wire logic		o_common_start_pin_oe,
	input	wire logic		o_common_stop_pin_o,
	input	wire logic		o_common_stop_pin_oe
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	////////////////////////////////////////////////////////////////////////////
	// Read strobe idle and clock enabled long enough for a refresh
	sequence quiet;
		(i_rd_n && i_clk_en)[*5];
	endsequence
	// A command taken at this edge
	sequence took(logic [7:0] c);
		i_cmd_wr && i_clk_en && i_cmd_code == c;
	endsequence

	////////////////////////////////////////////////////////////////////////////
	// Reserved bits and command responses
	chk_rsvd_zero: assert property (o_main_status[15] == 1'h0 && o_main_status[12] == 1'h0)
		else $error("reserved status bits set");
	chk_emg_pulse: assert property (took(CMD_EMG_ALL) |=> o_emg_all)
		else $error("emergency pulse missing");
	chk_start_pulse: assert property (i_cmd_wr && i_clk_en && i_cmd_code[7:2] == 6'h14 &&
		!i_sync_start_wait && o_run_condition == COND_IDLE
		|=> o_start_req && o_start_pattern == $past(i_cmd_code[1:0]))
		else $error("start request wrong");
	chk_start_oe: assert property (took(CMD_GRP_START) |=>
		(o_common_start_pin_oe && !o_common_start_pin_o)[*8])
		else $error("start pin pulse short");
	chk_stop_oe: assert property (took(CMD_GRP_STOP) |=>
		(o_common_stop_pin_oe && !o_common_stop_pin_o)[*8] ##1 o_common_stop_pin_oe[*2])
		else $error("stop pin pulse short");

	////////////////////////////////////////////////////////////////////////////
	// Status word contents after a quiet refresh window, and no change during a read
	chk_irq_off: assert property ((quiet and (!i_stop_irq_enable)[*5]) |-> !o_main_status[2])
		else $error("stop flag set while disabled");
	chk_err_bit: assert property ((quiet and $stable(i_error_factors)[*5]) |->
		o_main_status[4] == |i_error_factors)
		else $error("error flag wrong");
	chk_step_bits: assert property ((quiet and $stable(i_step_number_field)[*5]) |->
		o_main_status[7:6] == i_step_number_field)
		else $error("sequence bits wrong");
	chk_gp_bits: assert property ((quiet and $stable(i_gp_pin_levels)[*5]) |->
		o_sub_status[7:0] == i_gp_pin_levels)
		else $error("pin levels wrong");
	chk_read_freeze: assert property ((!i_rd_n)[*4] |=> $stable(o_main_status))
		else $error("status moved during read");
endmodule // ast_axis_monitor

bind ast_axis ast_axis_monitor mon_u (.*);

// [sim/ast_host.sv]
// Host processor model issuing commands and status reads
`timescale 1ns/1ps
module ast_host (
	input	wire logic		i_sys_clk,
	output	logic			o_cmd_wr,
	output	logic [7:0]		o_cmd_code,
	output	logic			o_rd_n
);
	initial begin
		o_cmd_wr = 1'h0;
		o_cmd_code = 8'h00;
		o_rd_n = 1'h1;
	end

	// One command, then an idle edge; code bus scrambled once released
	task automatic cmd(input logic [7:0] c);
		o_cmd_wr = 1'h1;
		o_cmd_code = c;
		@(posedge i_sys_clk);
		#1;
		o_cmd_wr = 1'h0;
		o_cmd_code = ~c;
		@(posedge i_sys_clk);
		#1;
	endtask

	// Read strobe low for four cycles
	task automatic rd_word;
		o_rd_n = 1'h0;
		repeat (4) @(posedge i_sys_clk);
		#1;
		o_rd_n = 1'h1;
	endtask
endmodule // ast_host
